// ===== ppm_pkg.sv
// Package of constants and types for the programmed power handshake.
package ppm_pkg;
   localparam int pstate_w = 2;
   localparam logic [1:0] pstate_d0 = 2'h0;
   localparam logic [1:0] pstate_d1 = 2'h1;
   localparam logic [1:0] pstate_d2 = 2'h2;
   localparam logic [1:0] pstate_d3hot = 2'h3;
   localparam logic [1:0] pstate_reset = 2'h0;
   typedef enum logic [2:0] {
      lk_detect, lk_l0, lk_l1, lk_notice, lk_ack_tx, lk_l23
   } link_state_t;
endpackage

// ===== ppm_if.sv
// Interface joining the core end and the user logic end.
`timescale 1ns/1ps
interface ppm_if;
   logic [1:0] power_state;
   logic requester_request_ready;
   logic req_valid;
   logic req_last;
   logic turnoff_notice;
   logic turnoff_ack;
   logic interfaces_closed;
   modport core (
      output power_state, requester_request_ready, turnoff_notice,
      output interfaces_closed,
      input req_valid, req_last, turnoff_ack
   );
   modport user (
      input power_state, requester_request_ready, turnoff_notice,
      input interfaces_closed,
      output req_valid, req_last, turnoff_ack
   );
endinterface

// ===== ppm_core.sv
// Core end of the programmed power handshake.
`timescale 1ns/1ps
module ppm_core
   import ppm_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // Link side events.
   input wire logic i_train_done,
   input wire logic i_pstate_wr,
   input wire logic [1:0] i_pstate_val,
   input wire logic i_turnoff_msg,
   input wire logic i_l1_done,
   // Link side outputs.
   output logic o_l1_request,
   output logic o_l23_request,
   output logic o_turnoff_ack_msg,
   output logic o_layers_off,
   output logic o_link_up,
   // User side.
   ppm_if.core u
);
   link_state_t st_ff, nxt_st;
   logic [1:0] pst_ff, nxt_pst;
   logic busy_ff, nxt_busy;
   logic ack_msg_ff, nxt_ack_msg;
   logic ack_s_ff, nxt_ack_s;
   logic closed;

   always_comb begin
      nxt_st = st_ff;
      nxt_pst = pst_ff;
      nxt_busy = busy_ff;
      nxt_ack_msg = 1'b0;
      nxt_ack_s = u.turnoff_ack;
      // Power state only changes by an upstream write.
      if (i_pstate_wr && !closed) begin
         nxt_pst = i_pstate_val;
      end
      // Track a request packet in progress.
      if (u.req_valid && (u.requester_request_ready)) begin
         nxt_busy = !u.req_last;
      end
      unique case (st_ff)
         lk_detect: begin
            if (i_train_done) begin
               nxt_st = lk_l0;
            end
         end
         lk_l0: begin
            if (i_turnoff_msg) begin
               nxt_st = lk_notice;
            end else if (pst_ff != pstate_d0) begin
               nxt_st = lk_l1;
            end
         end
         lk_l1: begin
            if (i_turnoff_msg) begin
               nxt_st = lk_notice;
            end else if (pst_ff == pstate_d0) begin
               nxt_st = lk_l0;
            end
         end
         lk_notice: begin
            if (ack_s_ff) begin
               nxt_st = lk_ack_tx;
               nxt_ack_msg = 1'b1;
            end
         end
         lk_ack_tx: begin
            nxt_st = lk_l23;
         end
         lk_l23: begin
            nxt_st = lk_l23;
         end
         default: begin
            nxt_st = lk_detect;
         end
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         st_ff <= lk_detect;
         pst_ff <= pstate_reset;
         busy_ff <= 1'b0;
         ack_msg_ff <= 1'b0;
         ack_s_ff <= 1'b0;
      end else if (i_ce) begin
         st_ff <= nxt_st;
         pst_ff <= nxt_pst;
         busy_ff <= nxt_busy;
         ack_msg_ff <= nxt_ack_msg;
         ack_s_ff <= nxt_ack_s;
      end
   end

   assign closed = (st_ff == lk_ack_tx) || (st_ff == lk_l23);
   assign u.power_state = pst_ff;
   // Ready holds for a packet already started; new ones wait for D0.
   assign u.requester_request_ready = !closed && (st_ff != lk_detect) &&
      (busy_ff || (pst_ff == pstate_d0));
   assign u.turnoff_notice = (st_ff == lk_notice);
   assign u.interfaces_closed = closed;
   assign o_l1_request = (st_ff == lk_l1) && !i_l1_done;
   assign o_l23_request = (st_ff == lk_notice);
   assign o_turnoff_ack_msg = ack_msg_ff;
   assign o_layers_off = (st_ff == lk_l23);
   assign o_link_up = (st_ff == lk_l0) || (st_ff == lk_l1) ||
      (st_ff == lk_notice);
endmodule

// ===== ppm_user.sv
// User logic end of the programmed power handshake.
`timescale 1ns/1ps
module ppm_user
   import ppm_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_ce,
   // User request source.
   input wire logic i_send,
   input wire logic i_last,
   input wire logic i_root_port,
   input wire logic i_safe_off,
   // Status to user.
   output logic o_sent,
   output logic o_committed,
   // Core side.
   ppm_if.user u
);
   logic pkt_ff, nxt_pkt;
   logic ack_ff, nxt_ack;
   logic allow;

   // Endpoint must not start requests out of D0; root port should not.
   assign allow = (u.power_state == pstate_d0) && !u.turnoff_notice &&
      !ack_ff && !u.interfaces_closed;

   always_comb begin
      nxt_pkt = pkt_ff;
      nxt_ack = ack_ff;
      if (u.req_valid && u.requester_request_ready) begin
         nxt_pkt = !i_last;
      end
      if (u.turnoff_notice && !pkt_ff && i_safe_off) begin
         nxt_ack = 1'b1;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pkt_ff <= 1'b0;
         ack_ff <= 1'b0;
      end else if (i_ce) begin
         pkt_ff <= nxt_pkt;
         ack_ff <= nxt_ack;
      end
   end

   assign u.req_valid = i_send && (pkt_ff || allow);
   assign u.req_last = i_last;
   assign u.turnoff_ack = ack_ff;
   assign o_sent = u.req_valid && u.requester_request_ready;
   assign o_committed = ack_ff;
endmodule

// ===== ppm_sva.sv
// Checker of the power handshake seen on the interface.
`timescale 1ns/1ps
module ppm_sva
   import ppm_pkg::*;
(
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_rst,
   // Interface signals.
   input wire logic [1:0] power_state,
   input wire logic requester_request_ready,
   input wire logic req_valid,
   input wire logic req_last,
   input wire logic turnoff_notice,
   input wire logic turnoff_ack,
   input wire logic interfaces_closed
);
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   sequence s_drop;
      turnoff_notice ##1 turnoff_notice ##1
         !turnoff_notice && interfaces_closed;
   endsequence
   sequence s_mid;
      req_valid && requester_request_ready && !req_last ##1 req_valid;
   endsequence
   a_ack_drops_notice: assert property ($rose(turnoff_ack) |-> s_drop)
      else $error("notice drop timing");
   a_notice_needs_ack: assert property (
      $fell(turnoff_notice) |-> $past(turnoff_ack, 2))
      else $error("notice dropped early");
   a_stall_non_d0: assert property (
      power_state != pstate_d0 && !req_valid |-> !requester_request_ready)
      else $error("ready in non-D0");
   a_mid_packet_ok: assert property (
      s_mid |-> requester_request_ready)
      else $error("mid packet stalled");
   a_closed_no_ready: assert property (
      interfaces_closed |-> !requester_request_ready)
      else $error("ready after close");
   a_closed_sticks: assert property (
      interfaces_closed |=> interfaces_closed)
      else $error("close lost");
   a_ack_sticks: assert property (turnoff_ack |=> turnoff_ack)
      else $error("ack withdrawn");
   a_ack_after_notice: assert property (
      $rose(turnoff_ack) |-> $past(turnoff_notice))
      else $error("ack without notice");
endmodule

// ===== tb_pcie_programmed_power_handshake.sv
// Bench for the two ends of the power handshake.
`timescale 1ns/1ps
module tb_pcie_programmed_power_handshake;
   import ppm_pkg::*;
   logic i_clk = 0, i_rst = 1, wr = 0, msg = 0, snd = 0, lst = 0;
   logic safe = 0, train = 0, l1_req, l23, ack_msg, off, up, sent, comm;
   logic [1:0] val = 2'h0;
   logic l1d = 0;
   int error_cnt = 0, n_tests = 0;
   ppm_if bus ();
   ppm_core u_ppm_core (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
      .i_train_done(train), .i_pstate_wr(wr), .i_pstate_val(val),
      .i_turnoff_msg(msg), .i_l1_done(l1d), .o_l1_request(l1_req),
      .o_l23_request(l23), .o_turnoff_ack_msg(ack_msg),
      .o_layers_off(off), .o_link_up(up), .u(bus));
   ppm_user u_ppm_user (.i_clk(i_clk), .i_rst(i_rst), .i_ce(1'b1),
      .i_send(snd), .i_last(lst), .i_root_port(1'b0), .i_safe_off(safe),
      .o_sent(sent), .o_committed(comm), .u(bus));
   ppm_sva u_ppm_sva (.i_clk(i_clk), .i_rst(i_rst),
      .power_state(bus.power_state),
      .requester_request_ready(bus.requester_request_ready),
      .req_valid(bus.req_valid), .req_last(bus.req_last),
      .turnoff_notice(bus.turnoff_notice), .turnoff_ack(bus.turnoff_ack),
      .interfaces_closed(bus.interfaces_closed));
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end
   task automatic test_done();
      $display("errors %0d checks %0d", error_cnt, n_tests);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task automatic chk(input string nm, input logic [1:0] e, g);
      n_tests++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic set_ps(input logic [1:0] s);
      wr = 1;
      val = s;
      @(negedge i_clk) wr = 0;
   endtask
   task automatic t_states();
      for (int s = 1; s < 5; s++) begin
         set_ps(2'(s));
         chk("state", 2'(s), bus.power_state);
         chk("ready", s == 4, bus.requester_request_ready);
         @(negedge i_clk);
         chk("l1", s != 4, l1_req);
         if (s == 3) begin
            l1d = 1;
            @(negedge i_clk);
            chk("l1 done", 0, l1_req);
            l1d = 0;
         end
      end
   endtask
   task automatic t_pkt();
      snd = 1;
      @(negedge i_clk) set_ps(2'h3);
      chk("ready mid", 1, bus.requester_request_ready);
      lst = 1;
      @(negedge i_clk) lst = 0;
      chk("ready after", 0, bus.requester_request_ready);
      @(negedge i_clk) chk("sent", 0, sent);
      snd = 0;
      set_ps(2'h0);
   endtask
   task automatic t_off();
      msg = 1;
      @(negedge i_clk) msg = 0;
      chk("notice", 1, bus.turnoff_notice);
      chk("l23", 1, l23);
      snd = 1;
      @(negedge i_clk) chk("no new pkt", 0, sent);
      snd = 0;
      repeat (3) @(negedge i_clk);
      chk("notice held", 1, bus.turnoff_notice);
      safe = 1;
      for (int i = 0; i < 20 && ack_msg !== 1'b1; i++) @(negedge i_clk);
      chk("ack msg", 1, ack_msg);
      chk("closed", 1, bus.interfaces_closed);
      @(negedge i_clk) chk("off", 1, off);
      chk("committed", 1, comm);
      set_ps(2'h1);
      chk("refused", 0, bus.power_state);
   endtask
   initial begin
      repeat (20) @(negedge i_clk);
      i_rst = 0;
      train = 1;
      @(negedge i_clk) chk("ready l0", 1, bus.requester_request_ready);
      chk("up", 1, up);
      t_states();
      t_pkt();
      t_off();
      test_done();
   end
   initial begin
      #100000;
      error_cnt++;
      test_done();
   end
endmodule
